//--- design/paired_timer_control.sv
// Lower timer control with optional 32-bit pairing to the upper timer
//
// How it works
// - Pair mode: run bit starts/stops 32-bit
// - Single mode: run bit starts/stops lower
// - Idle-halt bit stops counting in Idle
// - Internal clock: gate bit enables gating
// - External clock ignores gate bit
// - Prescale codes divide by 1/8/64/256
// - Pair bit joins timers into 32 bits
// - Pair clear: two separate 16-bit timers
// - Clock-source set counts pin rising edges
// - Clock-source clear counts instruction clock
// - Unimplemented control bits read zero
// - Pair mode ignores upper control, lower flag
// - Upper count holds high word
// - Upper period holds high word
`timescale 1ns/1ns
`include "paired_timer_map.svh"
module paired_timer_control (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire logic ext_count_pin,
  input wire logic ext_count_pin_high,
  input wire logic gate_in,
  input wire logic gate_in_high,
  input wire logic idle_mode,
  output logic irq
);
  logic [15:0] timer_control_reg, timer_control_next;
  logic [15:0] control_high_reg, control_high_next;
  logic [15:0] count_low_word_reg, count_low_word_next;
  logic [15:0] count_high_word_reg, count_high_word_next;
  logic [15:0] period_low_word_reg, period_low_word_next;
  logic [15:0] period_high_word_reg, period_high_word_next;
  logic [1:0] status_reg, status_next;
  logic [1:0] mask_reg, mask_next;
  logic [15:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic half_reg, half_next;
  paired_timer_pkg::gate_state_t gate_reg, gate_next;
  paired_timer_pkg::gate_state_t gate_hi_reg, gate_hi_next;

  logic pin_rise, gate_fall;
  logic pinh_rise, gateh_fall;
  logic pair, run_lo, run_hi, tick_lo, tick_hi;
  logic gated_lo, gated_hi;
  logic [1:0] events;
  logic [15:0] ctl_hi_eff;

  tick_if tk_lo ();
  tick_if tk_hi ();

  // Only the count edge and the gate fall are used
  edge_detect u_pin_lo (
    .ref_clk(ref_clk),
    .reset(reset),
    .level(ext_count_pin),
    .rise(pin_rise),
    .fall()
  );
  edge_detect u_gate_lo (
    .ref_clk(ref_clk),
    .reset(reset),
    .level(gate_in),
    .rise(),
    .fall(gate_fall)
  );
  edge_detect u_pin_hi (
    .ref_clk(ref_clk),
    .reset(reset),
    .level(ext_count_pin_high),
    .rise(pinh_rise),
    .fall()
  );
  edge_detect u_gate_hi (
    .ref_clk(ref_clk),
    .reset(reset),
    .level(gate_in_high),
    .rise(),
    .fall(gateh_fall)
  );
  // Upper prescaler sits cleared while paired
  timer_prescaler u_ps_lo (
    .ref_clk(ref_clk),
    .reset(reset),
    .tk(tk_lo)
  );
  timer_prescaler u_ps_hi (
    .ref_clk(ref_clk),
    .reset(reset),
    .tk(tk_hi)
  );

  // Instruction clock is ref_clk halved: one enable every second cycle
  always_comb begin
    half_next = ~half_reg;
  end

  // Source and gating selection for each timer
  always_comb begin
    pair = timer_control_reg[`BIT_PAIR];
    // In pair mode upper controls are ignored
    ctl_hi_eff = pair ? 16'h0000 : control_high_reg;
    run_lo = timer_control_reg[`BIT_RUN] &
      ~(idle_mode & timer_control_reg[`BIT_IDLE_HALT]);
    run_hi = ctl_hi_eff[`BIT_RUN] &
      ~(idle_mode & ctl_hi_eff[`BIT_IDLE_HALT]);
    gated_lo = ~timer_control_reg[`BIT_CLK_SRC] &
      timer_control_reg[`BIT_GATE];
    gated_hi = ~ctl_hi_eff[`BIT_CLK_SRC] & ctl_hi_eff[`BIT_GATE];
    if (timer_control_reg[`BIT_CLK_SRC]) begin
      tk_lo.src_tick = run_lo & pin_rise;
    end else begin
      tk_lo.src_tick = run_lo & half_reg &
        (~gated_lo | gate_in);
    end
    if (ctl_hi_eff[`BIT_CLK_SRC]) begin
      tk_hi.src_tick = run_hi & pinh_rise;
    end else begin
      tk_hi.src_tick = run_hi & half_reg & (~gated_hi | gate_in_high);
    end
    tk_lo.ratio = paired_timer_pkg::prescale_t'(
      timer_control_reg[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO]);
    tk_hi.ratio = paired_timer_pkg::prescale_t'(
      ctl_hi_eff[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO]);
    // Stop clears the prescaler but keeps the counts
    tk_lo.clear = ~run_lo;
    tk_hi.clear = ~run_hi;
    // A tick in flight still lands one edge after a stop
    tick_lo = tk_lo.count_tick;
    tick_hi = tk_hi.count_tick & ~pair;
  end

  // Counters, gate tracking and events
  always_comb begin
    count_low_word_next = count_low_word_reg;
    count_high_word_next = count_high_word_reg;
    gate_next = gate_reg;
    gate_hi_next = gate_hi_reg;
    events = 2'b00;
    if (pair) begin
      if (tick_lo) begin
        if ({count_high_word_reg, count_low_word_reg} ==
            {period_high_word_reg, period_low_word_reg}) begin
          count_low_word_next = 16'h0000;
          count_high_word_next = 16'h0000;
          events[`IRQ_HIGH] = ~gated_lo;
        end else begin
          // Carry ripples from low word into high word
          {count_high_word_next, count_low_word_next} =
            {count_high_word_reg, count_low_word_reg} + 32'h0000_0001;
        end
      end
    end else begin
      if (tick_lo) begin
        if (count_low_word_reg == period_low_word_reg) begin
          count_low_word_next = 16'h0000;
          events[`IRQ_LOW] = ~gated_lo;
        end else begin
          count_low_word_next = count_low_word_reg + 16'h0001;
        end
      end
      if (tick_hi) begin
        if (count_high_word_reg == period_high_word_reg) begin
          count_high_word_next = 16'h0000;
          events[`IRQ_HIGH] = ~gated_hi;
        end else begin
          count_high_word_next = count_high_word_reg + 16'h0001;
        end
      end
    end
    case (gate_reg)
      paired_timer_pkg::GATE_IDLE: begin
        if (gated_lo & run_lo & gate_in) begin
          gate_next = paired_timer_pkg::GATE_OPEN;
        end
      end
      paired_timer_pkg::GATE_OPEN: begin
        if (gate_fall) begin
          gate_next = paired_timer_pkg::GATE_IDLE;
          // Gate fall flag goes to the upper flag when paired
          if (pair) begin
            events[`IRQ_HIGH] = 1'b1;
          end else begin
            events[`IRQ_LOW] = 1'b1;
          end
        end else if (~gated_lo) begin
          gate_next = paired_timer_pkg::GATE_IDLE;
        end
      end
      default: gate_next = paired_timer_pkg::GATE_IDLE;
    endcase
    // Upper gate tracking, dead in pair mode
    case (gate_hi_reg)
      paired_timer_pkg::GATE_IDLE: begin
        if (gated_hi & run_hi & gate_in_high) begin
          gate_hi_next = paired_timer_pkg::GATE_OPEN;
        end
      end
      paired_timer_pkg::GATE_OPEN: begin
        if (gateh_fall) begin
          gate_hi_next = paired_timer_pkg::GATE_IDLE;
          events[`IRQ_HIGH] = 1'b1;
        end else if (~gated_hi) begin
          gate_hi_next = paired_timer_pkg::GATE_IDLE;
        end
      end
      default: gate_hi_next = paired_timer_pkg::GATE_IDLE;
    endcase
    // Software writes to the count win over counting
    if (wr_en && addr == `ADDR_COUNT_LOW) begin
      count_low_word_next = wdata;
    end
    if (wr_en && addr == `ADDR_COUNT_HIGH) begin
      count_high_word_next = wdata;
    end
  end

  // Register file and interrupt
  always_comb begin
    timer_control_next = timer_control_reg;
    control_high_next = control_high_reg;
    period_low_word_next = period_low_word_reg;
    period_high_word_next = period_high_word_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    if (wr_en) begin
      case (addr)
        `ADDR_CONTROL: timer_control_next = wdata & `CONTROL_WMASK;
        `ADDR_CONTROL_HIGH: control_high_next = wdata & `CONTROL_WMASK;
        `ADDR_PERIOD_LOW: period_low_word_next = wdata;
        `ADDR_PERIOD_HIGH: period_high_word_next = wdata;
        `ADDR_IRQ_MASK: mask_next = wdata[1:0];
        `ADDR_IRQ_STATUS: status_next = status_reg & ~wdata[1:0];
        default: status_next = status_reg;
      endcase
    end
    // New events win over a clearing write
    status_next = status_next | events;
    rdata_next = 16'h0000;
    if (rd_en) begin
      case (addr)
        `ADDR_CONTROL: rdata_next = timer_control_reg;
        `ADDR_CONTROL_HIGH: rdata_next = control_high_reg;
        `ADDR_COUNT_LOW: rdata_next = count_low_word_reg;
        `ADDR_COUNT_HIGH: rdata_next = count_high_word_reg;
        `ADDR_PERIOD_LOW: rdata_next = period_low_word_reg;
        `ADDR_PERIOD_HIGH: rdata_next = period_high_word_reg;
        `ADDR_IRQ_STATUS: rdata_next = {14'h0000, status_reg};
        `ADDR_IRQ_MASK: rdata_next = {14'h0000, mask_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
    // Next mask, so a mask write acts on the very next cycle
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timer_control_reg <= `CONTROL_RESET;
      control_high_reg <= `CONTROL_RESET;
      count_low_word_reg <= 16'h0000;
      count_high_word_reg <= 16'h0000;
      period_low_word_reg <= `PERIOD_RESET;
      period_high_word_reg <= `PERIOD_RESET;
      status_reg <= 2'h0;
      mask_reg <= 2'h0;
      rdata_reg <= 16'h0000;
      irq_reg <= 1'b0;
      half_reg <= 1'b0;
      gate_reg <= paired_timer_pkg::GATE_IDLE;
      gate_hi_reg <= paired_timer_pkg::GATE_IDLE;
    end else begin
      timer_control_reg <= timer_control_next;
      control_high_reg <= control_high_next;
      count_low_word_reg <= count_low_word_next;
      count_high_word_reg <= count_high_word_next;
      period_low_word_reg <= period_low_word_next;
      period_high_word_reg <= period_high_word_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      half_reg <= half_next;
      gate_reg <= gate_next;
      gate_hi_reg <= gate_hi_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
endmodule

//--- design/paired_timer_map.svh
// Register offsets, field positions, reset values, write mask and interrupt bits of the timer
`ifndef PAIRED_TIMER_MAP_SVH
`define PAIRED_TIMER_MAP_SVH
`define ADDR_CONTROL 4'h0
`define ADDR_COUNT_LOW 4'h1
`define ADDR_COUNT_HIGH 4'h2
`define ADDR_PERIOD_LOW 4'h3
`define ADDR_PERIOD_HIGH 4'h4
`define ADDR_IRQ_STATUS 4'h5
`define ADDR_IRQ_MASK 4'h6
`define ADDR_CONTROL_HIGH 4'h7
`define BIT_RUN 15
`define BIT_IDLE_HALT 13
`define BIT_GATE 6
`define BIT_PRESCALE_HI 5
`define BIT_PRESCALE_LO 4
`define BIT_PAIR 3
`define BIT_CLK_SRC 1
`define CONTROL_WMASK 16'ha07a
`define CONTROL_RESET 16'h0000
`define PERIOD_RESET 16'hffff
`define IRQ_LOW 0
`define IRQ_HIGH 1
`endif

//--- design/paired_timer_pkg.sv
// Types shared by the paired timer modules
package paired_timer_pkg;
  typedef enum logic [1:0] {
    PS_DIV1,
    PS_DIV8,
    PS_DIV64,
    PS_DIV256
  } prescale_t;
  typedef enum {
    GATE_IDLE,
    GATE_OPEN
  } gate_state_t;
endpackage

//--- design/tick_if.sv
// Count enable path between the timer modules
`timescale 1ns/1ns
interface tick_if;
  logic src_tick;
  logic count_tick;
  paired_timer_pkg::prescale_t ratio;
  logic clear;
  modport producer (input src_tick, input ratio, input clear,
    output count_tick);
  modport consumer (output src_tick, output ratio, output clear,
    input count_tick);
endinterface

//--- design/timer_prescaler.sv
// Prescaler that turns source ticks into count ticks
`timescale 1ns/1ns
module timer_prescaler (
  input wire logic ref_clk,
  input wire logic reset,
  tick_if.producer tk
);
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic tick_reg;
  logic tick_next;
  logic [7:0] last;

  always_comb begin
    case (tk.ratio)
      paired_timer_pkg::PS_DIV8: last = 8'h07;
      paired_timer_pkg::PS_DIV64: last = 8'h3f;
      paired_timer_pkg::PS_DIV256: last = 8'hff;
      default: last = 8'h00;
    endcase
    div_next = div_reg;
    tick_next = 1'b0;
    if (tk.clear) begin
      div_next = 8'h00;
    end else if (tk.src_tick) begin
      if (div_reg >= last) begin
        div_next = 8'h00;
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tk.count_tick = tick_reg;
endmodule

//--- design/edge_detect.sv
// Rising and falling edge finder for a synchronous input
`timescale 1ns/1ns
module edge_detect (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic last_reg;
  logic last_next;

  always_comb begin
    last_next = level;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= last_next;
    end
  end

  assign rise = level & ~last_reg;
  assign fall = ~level & last_reg;
endmodule

//--- test/paired_timer_control_chk.sv
// Port-level assertions for the paired timer control
`timescale 1ns/1ns
`include "paired_timer_map.svh"
module paired_timer_control_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rdata,
  input wire logic ext_count_pin,
  input wire logic ext_count_pin_high,
  input wire logic gate_in,
  input wire logic gate_in_high,
  input wire logic idle_mode,
  input wire logic irq
);
  logic [15:0] ctl_reg, ctl_next;
  logic [3:0] quiet_reg, quiet_next;
  logic [2:0] pins_reg, pins_next;
  logic cl_rd, run, free_run, idle_stop, ext_still, gate_shut;
  // Shadow control and settle time, so pipeline ticks never trip a check
  always_comb begin
    ctl_next = ctl_reg;
    pins_next = {idle_mode, ext_count_pin, gate_in};
    quiet_next = quiet_reg + {3'h0, quiet_reg != 4'hf};
    if (wr_en && addr == `ADDR_CONTROL) begin
      ctl_next = wdata & `CONTROL_WMASK;
      quiet_next = 4'h0;
    end
    if (pins_next != pins_reg) begin
      quiet_next = 4'h0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl_reg <= `CONTROL_RESET;
      quiet_reg <= 4'h0;
      pins_reg <= 3'h0;
    end else begin
      ctl_reg <= ctl_next;
      quiet_reg <= quiet_next;
      pins_reg <= pins_next;
    end
  end
  assign cl_rd = rd_en && !wr_en && addr == `ADDR_COUNT_LOW;
  assign run = ctl_reg[`BIT_RUN];
  assign idle_stop = run && ctl_reg[`BIT_IDLE_HALT] && idle_mode;
  assign ext_still = run && ctl_reg[`BIT_CLK_SRC];
  assign gate_shut = run && !ctl_reg[`BIT_CLK_SRC] && ctl_reg[`BIT_GATE] &&
    !gate_in;
  assign free_run = run && ctl_reg[6:4] == 3'h0 && !ctl_reg[`BIT_CLK_SRC] &&
    !idle_stop;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  property hold_p(cond);
    cl_rd ##1 !wr_en ##1 (cl_rd && cond && quiet_reg >= 4'ha)
      |=> rdata == $past(rdata, 2);
  endproperty
  hold_off_a: assert property (hold_p(!run))
    else $error("count moved while stopped");
  hold_idle_a: assert property (hold_p(idle_stop))
    else $error("count moved in idle with halt set");
  hold_ext_a: assert property (hold_p(ext_still))
    else $error("count moved with no pin edge");
  hold_gate_a: assert property (hold_p(gate_shut))
    else $error("count moved with gate low");
  free_advance_a: assert property (
    cl_rd ##1 !wr_en [*3] ##1 (cl_rd && free_run && quiet_reg >= 4'hc)
    |=> rdata != $past(rdata, 4)) else $error("count did not advance");
  resv_zero_a: assert property (
    (rd_en && addr == `ADDR_CONTROL) |=> (rdata & ~`CONTROL_WMASK) == 16'h0)
    else $error("reserved control bits read nonzero");
  unmapped_zero_a: assert property (
    (rd_en && addr > `ADDR_CONTROL_HIGH) |=> rdata == 16'h0000)
    else $error("unmapped read nonzero");
  rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 16'h0)
    else $error("read data outside read slot");
  ctl_readback_a: assert property (
    (wr_en && addr == `ADDR_CONTROL) ##1 (rd_en && addr == `ADDR_CONTROL)
    |=> rdata == ($past(wdata, 2) & `CONTROL_WMASK))
    else $error("control readback wrong");
  irq_mask_a: assert property (
    (wr_en && addr == `ADDR_IRQ_MASK && wdata[1:0] == 2'h0) |-> ##2 !irq)
    else $error("irq high with all masked");
  cover property ($rose(irq));
  cover property (cl_rd && free_run);
  cover property (wr_en && addr == `ADDR_CONTROL && wdata[`BIT_PAIR]);
endmodule
bind paired_timer_control paired_timer_control_chk chk (
  .ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .ext_count_pin(ext_count_pin), .ext_count_pin_high(ext_count_pin_high),
  .gate_in(gate_in), .gate_in_high(gate_in_high), .idle_mode(idle_mode),
  .irq(irq)
);

//--- test/tb_paired_timer_control.sv
// Self-checking bench for the paired timer control block
`timescale 1ns/1ns
`include "paired_timer_map.svh"
module tb_paired_timer_control;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ext_count_pin = 1'b0;
  logic gate_in = 1'b0;
  logic idle_mode = 1'b0;
  logic ext_count_pin_high = 1'b0;
  logic gate_in_high = 1'b0;
  logic [15:0] rdata, v, w;
  logic irq;
  int bad_count = 0;
  int checks = 0;
  int div_tab[4] = '{1, 8, 64, 256};
  always #25 ref_clk = ~ref_clk;
  paired_timer_control dut (.ref_clk(ref_clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .ext_count_pin(ext_count_pin), .ext_count_pin_high(ext_count_pin_high),
    .gate_in(gate_in), .gate_in_high(gate_in_high), .idle_mode(idle_mode),
    .irq(irq));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Tick phase and pipeline lag allow one count either way
  task automatic near(input logic [15:0] got, input logic [15:0] exp);
    check({15'h0, got + 16'h1 >= exp && got <= exp + 16'h1}, 16'h1);
  endtask
  // Strobe stays up on return so writes can run back to back
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  task automatic quiet(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic irq_is(input logic exp);
    #1;
    check({15'h0, irq}, {15'h0, exp});
    @(posedge ref_clk);
  endtask
  task automatic run_for(input logic [15:0] ctl, input int n,
      output logic [15:0] d);
    logic [15:0] e;
    wr(`ADDR_COUNT_LOW, 16'h0);
    wr(`ADDR_CONTROL, ctl);
    quiet(n);
    wr(`ADDR_CONTROL, ctl & 16'h7fff);
    quiet(10);
    rd(`ADDR_COUNT_LOW, d);
    rd(`ADDR_COUNT_LOW, e);
    check(e, d);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rdc(`ADDR_CONTROL, `CONTROL_RESET);
    rdc(`ADDR_PERIOD_LOW, `PERIOD_RESET);
    rdc(4'h9, 16'h0);
    wr(`ADDR_CONTROL, 16'h7fff);
    rdc(`ADDR_CONTROL, 16'h207a);
    for (int k = 0; k < 4; k++) begin
      // 20*N enabled edges hold exactly 10*N source ticks, any phase
      run_for(16'h8000 | {10'h0, k[1:0], 4'h0}, 20 * div_tab[k] - 1, v);
      check(v, 16'h000a);
    end
    wr(`ADDR_PERIOD_LOW, 16'h0003);
    // 42 enabled edges: 21 counts through a period of 4 ends on 1
    run_for(16'h8000, 41, v);
    check(v, 16'h0001);
    rdc(`ADDR_COUNT_HIGH, 16'h0);
    rdc(`ADDR_IRQ_STATUS, 16'h0001);
    wr(`ADDR_IRQ_STATUS, 16'h0003);
    rdc(`ADDR_IRQ_STATUS, 16'h0);
    // Upper run set on purpose: pair mode must not let it count
    wr(`ADDR_CONTROL, 16'h0008);
    wr(`ADDR_CONTROL_HIGH, 16'h8000);
    wr(`ADDR_PERIOD_HIGH, 16'h0001);
    wr(`ADDR_PERIOD_LOW, 16'h0008);
    wr(`ADDR_COUNT_LOW, 16'hfffe);
    wr(`ADDR_CONTROL, 16'h8008);
    quiet(14);
    wr(`ADDR_CONTROL, 16'h0008);
    rdc(`ADDR_COUNT_HIGH, 16'h0001);
    wr(`ADDR_CONTROL, 16'h8008);
    quiet(40);
    wr(`ADDR_CONTROL, 16'h0008);
    rdc(`ADDR_IRQ_STATUS, 16'h0002);
    irq_is(1'b0);
    wr(`ADDR_IRQ_MASK, 16'h0002);
    quiet(2);
    irq_is(1'b1);
    wr(`ADDR_IRQ_STATUS, 16'h0002);
    quiet(2);
    irq_is(1'b0);
    wr(`ADDR_IRQ_MASK, 16'h0);
    wr(`ADDR_CONTROL_HIGH, 16'h0);
    wr(`ADDR_PERIOD_HIGH, `PERIOD_RESET);
    wr(`ADDR_PERIOD_LOW, `PERIOD_RESET);
    wr(`ADDR_COUNT_LOW, 16'h0);
    idle_mode <= 1'b1;
    wr(`ADDR_CONTROL, 16'ha000);
    quiet(12);
    rdc(`ADDR_COUNT_LOW, 16'h0);
    rdc(`ADDR_COUNT_LOW, 16'h0);
    wr(`ADDR_CONTROL, 16'h8000);
    quiet(12);
    rd(`ADDR_COUNT_LOW, v);
    rd(`ADDR_COUNT_LOW, w);
    rd(`ADDR_COUNT_LOW, w);
    check({15'h0, w != v}, 16'h1);
    // Stop first: a tick in flight would land after the clear
    wr(`ADDR_CONTROL, 16'h0);
    idle_mode <= 1'b0;
    wr(`ADDR_COUNT_HIGH, 16'h0);
    wr(`ADDR_COUNT_LOW, 16'h0);
    // Upper timer on its own pin, gate bit set but ignored
    wr(`ADDR_CONTROL_HIGH, 16'h8042);
    wr(`ADDR_CONTROL, 16'h8042);
    quiet(4);
    for (int i = 0; i < 5; i++) begin
      ext_count_pin <= 1'b1;
      ext_count_pin_high <= 1'b1;
      quiet(3);
      ext_count_pin <= 1'b0;
      ext_count_pin_high <= 1'b0;
      quiet(3);
    end
    quiet(10);
    rdc(`ADDR_COUNT_LOW, 16'h0005);
    rdc(`ADDR_COUNT_LOW, 16'h0005);
    rdc(`ADDR_COUNT_HIGH, 16'h0005);
    wr(`ADDR_COUNT_LOW, 16'h0);
    wr(`ADDR_CONTROL, 16'h8040);
    quiet(12);
    rdc(`ADDR_COUNT_LOW, 16'h0);
    rdc(`ADDR_COUNT_LOW, 16'h0);
    gate_in <= 1'b1;
    gate_in_high <= 1'b1;
    quiet(20);
    gate_in <= 1'b0;
    gate_in_high <= 1'b0;
    quiet(6);
    wr(`ADDR_CONTROL, 16'h0);
    rd(`ADDR_COUNT_LOW, v);
    near(v, 16'h000a);
    rdc(`ADDR_IRQ_STATUS, 16'h0001);
    quiet(2);
    tally_and_finish();
  end
endmodule
